// *** enc_read_assertions.sv ***
// checker on the signals of the read port interface
// assumes the testbench instantiates it beside the interface, one clock
`default_nettype none

module enc_read_assertions
(
	input wire logic core_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic byte_sel, // byte select
	input wire logic bus_en_n, // bus enable, active low
	input wire logic [7:0] data_out, // device byte
	input wire logic data_oe, // device drives lines
	input wire logic decoder_count_pulse, // count pulse
	input wire logic carry_borrow_pulse, // cascade pulse
	input wire logic up_down // direction
);
	timeunit 1ns;
	timeprecision 1ps;

	// drive window follows enable exactly
	a_oe_follows_en: assert property (@(posedge core_clk) disable iff (rst)
		data_oe == !bus_en_n) else $error("data drive differs from enable");
	// half wide pulses are always low again by the next rise
	a_count_half_wide: assert property (@(posedge core_clk) disable iff (rst)
		!decoder_count_pulse) else $error("count pulse still high at rise");
	a_cascade_half_wide: assert property (@(posedge core_clk) disable iff (rst)
		!carry_borrow_pulse) else $error("cascade pulse still high at rise");
	// a wrap is always also a count
	a_cascade_with_count: assert property (@(negedge core_clk) disable iff (rst)
		carry_borrow_pulse |-> decoder_count_pulse) else $error("cascade without count");
	// direction steady across the pulse rise
	a_dir_steady: assert property (@(negedge core_clk) disable iff (rst)
		decoder_count_pulse |-> $stable(up_down)) else $error("direction moved at pulse");
	// direction still held one cycle after the pulse rise
	a_dir_hold: assert property (@(negedge core_clk) disable iff (rst)
		decoder_count_pulse |=> $stable(up_down)) else $error("direction moved after pulse");
	// two byte read: high byte, low byte, release
	a_high_then_low: assert property (@(posedge core_clk) disable iff (rst)
		$fell(bus_en_n) && !byte_sel |=> byte_sel && !bus_en_n ##1 bus_en_n)
		else $error("two byte read out of order");
	// single byte read keeps select high
	a_single_byte: assert property (@(posedge core_clk) disable iff (rst)
		$fell(bus_en_n) && byte_sel |=> bus_en_n && byte_sel)
		else $error("single byte read malformed");
	// high byte is only selected inside a read
	a_sel_in_read: assert property (@(posedge core_clk) disable iff (rst)
		!byte_sel |-> !bus_en_n) else $error("select low outside a read");
endmodule

`default_nettype wire

// *** enc_read_if.sv ***
// interface joining the encoder count read port to its bus reader
// assumes the testbench resolves the data lines from data_oe
`default_nettype none

interface enc_read_if;
	logic byte_sel; // low selects high byte, high selects low byte
	logic bus_en_n; // bus enable, active low
	logic [7:0] data_out; // byte driven by the device
	logic data_oe; // high while the device drives the data lines
	logic decoder_count_pulse; // half-cycle pulse per decoded count
	logic carry_borrow_pulse; // half-cycle pulse per overflow or underflow
	logic up_down; // high for up counts

	// device end
	modport dev
	(
		input byte_sel,
		input bus_en_n,
		output data_out,
		output data_oe,
		output decoder_count_pulse,
		output carry_borrow_pulse,
		output up_down
	);

	// reader end
	modport host
	(
		output byte_sel,
		output bus_en_n,
		input data_out,
		input data_oe,
		input decoder_count_pulse,
		input carry_borrow_pulse,
		input up_down
	);
endinterface

`default_nettype wire

// *** enc_read_pkg.sv ***
// shared constants and types for the encoder count read port and its reader
// assumes both ends run on one clock and include no other package
`default_nettype none

package enc_read_pkg;

	localparam int COUNT_W = 16; // width of counter and position latch
	localparam int BYTE_W = 8; // width of the data lines
	localparam logic [15:0] COUNT_RST = 16'h0000; // counter value after reset
	localparam logic [15:0] LATCH_RST = 16'h0000; // latch value after reset
	localparam logic [15:0] COUNT_MAX = 16'hffff; // value that overflows on an up count
	localparam logic [15:0] COUNT_MIN = 16'h0000; // value that underflows on a down count
	localparam int HI_LSB = 8; // lowest bit of the high byte
	localparam logic [7:0] EXT_RST = 8'h00; // reader's external cascade counter after reset
	localparam logic [1:0] PHASE_RST = 2'h0; // phase history after reset

	// inhibit sequence, stepped on falling edges
	typedef enum logic [1:0]
	{
		INH_IDLE = 2'b00, // latch follows counter
		INH_HELD = 2'b01, // high byte read, latch frozen
		INH_RELEASE = 2'b10 // low byte read, waiting for bus enable high
	} inhibit_state_t;

	// reader sequence
	typedef enum logic [2:0]
	{
		RD_IDLE = 3'b000, // bus idle, select high, enable high
		RD_HIGH = 3'b001, // high byte on the lines
		RD_LOW = 3'b010, // low byte on the lines
		RD_RELEASE = 3'b011, // enable high, inhibit releasing
		RD_SINGLE = 3'b100 // single byte read
	} reader_state_t;

endpackage

`default_nettype wire

// *** encoder_bus_reader.sv ***
// reader end: performs one or two byte reads and keeps an 8-bit cascade counter
// assumes the device end shares core_clk and samples the bus on falling edges
`default_nettype none

module encoder_bus_reader
(
	input wire logic core_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes state when low
	enc_read_if.host bus, // device side
	input wire logic read_req, // one-cycle request to start a read
	input wire logic wide_read, // high: two-byte read, low: single byte
	output logic read_busy, // high while a read is running
	output logic read_done, // one-cycle pulse when read_data is valid
	output logic [15:0] read_data, // last value read
	output logic [7:0] ext_latched // cascade count caught at high byte start
);

	// sequence group
	enc_read_pkg::reader_state_t st_r, st_nxt; // reader state
	logic sel_r, sel_nxt; // byte select drive
	logic en_n_r, en_n_nxt; // bus enable drive, active low
	logic busy_r, busy_nxt; // busy flag
	logic done_r, done_nxt; // done pulse
	logic [15:0] data_r, data_nxt; // assembled value
	logic [7:0] ext_cnt_r, ext_cnt_nxt; // external cascade counter
	logic [7:0] ext_lat_r, ext_lat_nxt; // external cascade latch

	// falling edge catch of the half-cycle cascade pulse and its direction
	logic cas_seen_r, cas_seen_nxt; // cascade pulse seen
	logic cas_up_r, cas_up_nxt; // direction with it

	// next values of the read sequence and cascade counter
	always_comb
	begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		en_n_nxt = en_n_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		data_nxt = data_r;
		ext_cnt_nxt = ext_cnt_r;
		ext_lat_nxt = ext_lat_r;
		// the carry or borrow counts even during a read
		if (cas_seen_r)
		begin
			ext_cnt_nxt = cas_up_r ? ext_cnt_r + 8'h01 : ext_cnt_r - 8'h01;
		end
		case (st_r)
			enc_read_pkg::RD_IDLE:
			begin
				if (read_req && wide_read)
				begin
					sel_nxt = 1'b0;
					en_n_nxt = 1'b0;
					busy_nxt = 1'b1;
					ext_lat_nxt = ext_cnt_r;
					st_nxt = enc_read_pkg::RD_HIGH;
				end
				else if (read_req)
				begin
					// select stays high, the device never freezes
					en_n_nxt = 1'b0;
					busy_nxt = 1'b1;
					st_nxt = enc_read_pkg::RD_SINGLE;
				end
			end
			enc_read_pkg::RD_HIGH:
			begin
				data_nxt[15:8] = bus.data_out;
				sel_nxt = 1'b1;
				st_nxt = enc_read_pkg::RD_LOW;
			end
			enc_read_pkg::RD_LOW:
			begin
				data_nxt[7:0] = bus.data_out;
				en_n_nxt = 1'b1;
				st_nxt = enc_read_pkg::RD_RELEASE;
			end
			enc_read_pkg::RD_RELEASE:
			begin
				// falling edge of this cycle sees enable high
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				st_nxt = enc_read_pkg::RD_IDLE;
			end
			enc_read_pkg::RD_SINGLE:
			begin
				data_nxt = {8'h00, bus.data_out};
				en_n_nxt = 1'b1;
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				st_nxt = enc_read_pkg::RD_IDLE;
			end
			default:
			begin
				st_nxt = enc_read_pkg::RD_IDLE;
				sel_nxt = 1'b1;
				en_n_nxt = 1'b1;
				busy_nxt = 1'b0;
			end
		endcase
	end

	// sequence registers, bus pins change on rising edges only
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r <= enc_read_pkg::RD_IDLE;
			sel_r <= 1'b1;
			en_n_r <= 1'b1;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			data_r <= enc_read_pkg::COUNT_RST;
			ext_cnt_r <= enc_read_pkg::EXT_RST;
			ext_lat_r <= enc_read_pkg::EXT_RST;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			en_n_r <= en_n_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			data_r <= data_nxt;
			ext_cnt_r <= ext_cnt_nxt;
			ext_lat_r <= ext_lat_nxt;
		end
	end

	// pulse is high only in the first half cycle, so catch it before the fall
	always_comb
	begin
		cas_seen_nxt = bus.carry_borrow_pulse;
		cas_up_nxt = bus.up_down;
	end

	// falling edge catch registers
	always_ff @(negedge core_clk)
	begin
		if (rst)
		begin
			cas_seen_r <= 1'b0;
			cas_up_r <= 1'b1;
		end
		else if (ce)
		begin
			cas_seen_r <= cas_seen_nxt;
			cas_up_r <= cas_up_nxt;
		end
	end

	assign bus.byte_sel = sel_r;
	assign bus.bus_en_n = en_n_r;
	assign read_busy = busy_r;
	assign read_done = done_r;
	assign read_data = data_r;
	assign ext_latched = ext_lat_r;

endmodule

`default_nettype wire

// *** encoder_count_read_port.sv ***
// device end: 16-bit encoder counter, inhibitable position latch, byte mux,
// decoder and cascade pulse outputs
// assumes the reader drives select and enable from core_clk rising edges
//
// Overview of operation
// - inhibit samples select and enable on falling edges
// - reset clears inhibit at once, no clock needed
// - select low gives high byte, high gives low
// - drive lines while enable low, release otherwise
// - half-clock count pulse when counter updates
// - direction valid one cycle around pulse edge
// - half-clock cascade pulse on overflow or underflow
// - pulse and direction outputs ignore the inhibit
// - select and enable low set inhibit
// - select high, enable low starts release
// - then enable high clears the inhibit
// - latch copies counter on rising edge unless inhibited
// - counter keeps counting while latch is frozen
// - select held high never engages the inhibit
// - reader changes select and enable on clock
// - reader fetches high byte before low byte
// - external cascade latches when high read begins
// - a leading b or a skipped state counts up, else down
`default_nettype none

module encoder_count_read_port
#(
	parameter int COUNT_W = enc_read_pkg::COUNT_W // counter width
)
(
	input wire logic core_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic encoder_phase_a, // phase a pin
	input wire logic encoder_phase_b, // phase b pin
	enc_read_if.dev bus, // reader side
	output logic [COUNT_W-1:0] count_value, // live counter value
	output logic latch_frozen // high while the latch is inhibited
);

	localparam int HI_LSB = enc_read_pkg::HI_LSB; // high byte position

	// decoder outputs
	logic step; // decoded step strobe
	logic step_up; // decoded direction

	// rising edge group
	logic [COUNT_W-1:0] count_r, count_nxt; // position counter
	logic [COUNT_W-1:0] latch_r, latch_nxt; // position latch
	logic pend_r, pend_nxt; // step waiting one cycle behind direction
	logic dir_r, dir_nxt; // direction output register
	logic dcdr_tog_r, dcdr_tog_nxt; // toggles at each counter update
	logic cas_tog_r, cas_tog_nxt; // toggles at each overflow or underflow

	// falling edge group
	enc_read_pkg::inhibit_state_t inh_r, inh_nxt; // inhibit sequence
	logic dcdr_echo_r, dcdr_echo_nxt; // copy of count toggle, half a cycle late
	logic cas_echo_r, cas_echo_nxt; // copy of cascade toggle, half a cycle late
	logic inhibit; // effective inhibit, reset masks it without a clock

	// step and direction from the phase pins
	quad_step_decoder u_decoder
	(
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.encoder_phase_a(encoder_phase_a),
		.encoder_phase_b(encoder_phase_b),
		.step_r(step),
		.step_up_r(step_up)
	);

	// reset kills the inhibit combinationally so the latch reopens at once
	assign inhibit = (inh_r != enc_read_pkg::INH_IDLE) && !rst;

	// counter, latch and pulse sources
	always_comb
	begin
		count_nxt = count_r;
		latch_nxt = latch_r;
		pend_nxt = step;
		dir_nxt = dir_r;
		dcdr_tog_nxt = dcdr_tog_r;
		cas_tog_nxt = cas_tog_r;
		// direction moves one cycle ahead of the count update
		if (step)
		begin
			dir_nxt = step_up;
		end
		// counter update, independent of the latch inhibit
		if (pend_r)
		begin
			if (dir_r)
			begin
				count_nxt = count_r + COUNT_W'(1);
			end
			else
			begin
				count_nxt = count_r - COUNT_W'(1);
			end
			dcdr_tog_nxt = !dcdr_tog_r;
			// wrap of the counter fires the cascade pulse
			if ((dir_r && count_r == enc_read_pkg::COUNT_MAX) ||
				(!dir_r && count_r == enc_read_pkg::COUNT_MIN))
			begin
				cas_tog_nxt = !cas_tog_r;
			end
		end
		// latch follows the counter unless frozen for a read
		if (!inhibit)
		begin
			latch_nxt = count_r;
		end
	end

	// rising edge registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			count_r <= enc_read_pkg::COUNT_RST;
			latch_r <= enc_read_pkg::LATCH_RST;
			pend_r <= 1'b0;
			dir_r <= 1'b1;
			dcdr_tog_r <= 1'b0;
			cas_tog_r <= 1'b0;
		end
		else if (ce)
		begin
			count_r <= count_nxt;
			latch_r <= latch_nxt;
			pend_r <= pend_nxt;
			dir_r <= dir_nxt;
			dcdr_tog_r <= dcdr_tog_nxt;
			cas_tog_r <= cas_tog_nxt;
		end
	end

	// inhibit sequence and pulse echoes, decided at falling edges
	always_comb
	begin
		inh_nxt = inh_r;
		dcdr_echo_nxt = dcdr_tog_r;
		cas_echo_nxt = cas_tog_r;
		case (inh_r)
			enc_read_pkg::INH_IDLE:
			begin
				// high byte read opens the freeze; select high never does
				if (!bus.byte_sel && !bus.bus_en_n)
				begin
					inh_nxt = enc_read_pkg::INH_HELD;
				end
			end
			enc_read_pkg::INH_HELD:
			begin
				// low byte read arms the release, latch stays frozen
				if (bus.byte_sel && !bus.bus_en_n)
				begin
					inh_nxt = enc_read_pkg::INH_RELEASE;
				end
			end
			enc_read_pkg::INH_RELEASE:
			begin
				// enable high finishes the release
				if (bus.bus_en_n)
				begin
					inh_nxt = enc_read_pkg::INH_IDLE;
				end
			end
			default:
			begin
				inh_nxt = enc_read_pkg::INH_IDLE;
			end
		endcase
	end

	// falling edge registers
	always_ff @(negedge core_clk)
	begin
		if (rst)
		begin
			inh_r <= enc_read_pkg::INH_IDLE;
			dcdr_echo_r <= 1'b0;
			cas_echo_r <= 1'b0;
		end
		else if (ce)
		begin
			inh_r <= inh_nxt;
			dcdr_echo_r <= dcdr_echo_nxt;
			cas_echo_r <= cas_echo_nxt;
		end
	end

	// pulse is high from the updating rising edge to the next falling edge
	assign bus.decoder_count_pulse = dcdr_tog_r ^ dcdr_echo_r;
	assign bus.carry_borrow_pulse = cas_tog_r ^ cas_echo_r;
	assign bus.up_down = dir_r;

	// byte mux and output enable follow the bus pins directly
	assign bus.data_out = bus.byte_sel ? latch_r[HI_LSB-1:0] : latch_r[COUNT_W-1:HI_LSB];
	assign bus.data_oe = !bus.bus_en_n;

	// user side status
	assign count_value = count_r;
	assign latch_frozen = inhibit;

endmodule

`default_nettype wire

// *** quad_step_decoder.sv ***
// quadrature decoder: synchronises both phases and reports one step per state change
// assumes phase inputs are asynchronous pins and core_clk is the only clock
`default_nettype none

module quad_step_decoder
(
	input wire logic core_clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic encoder_phase_a, // raw phase a pin
	input wire logic encoder_phase_b, // raw phase b pin
	output logic step_r, // one-cycle step strobe
	output logic step_up_r // direction of the last step
);

	localparam logic [1:0] PHASE_RST_L = enc_read_pkg::PHASE_RST; // history reset value

	logic [1:0] sync1_r, sync1_nxt; // first synchroniser stage {a,b}
	logic [1:0] sync2_r, sync2_nxt; // second synchroniser stage
	logic [1:0] prev_r, prev_nxt; // last decoded phase state
	logic step_nxt; // next step strobe
	logic step_up_nxt; // next direction

	// position of a phase pair in the up sequence 10,11,01,00
	function automatic logic [1:0] phase_index(input logic [1:0] ab);
		logic [1:0] idx;
		idx = 2'h0;
		case (ab)
			2'b10: idx = 2'h0;
			2'b11: idx = 2'h1;
			2'b01: idx = 2'h2;
			default: idx = 2'h3;
		endcase
		return idx;
	endfunction

	// step and direction from old and new state
	always_comb
	begin
		sync1_nxt = {encoder_phase_a, encoder_phase_b};
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
		step_nxt = (sync2_r != prev_r);
		step_up_nxt = step_up_r;
		if (sync2_r != prev_r)
		begin
			// a leading b walks the index upward; a skipped state counts up
			step_up_nxt = (phase_index(sync2_r) != (phase_index(prev_r) - 2'h1));
		end
	end

	// register stage
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sync1_r <= PHASE_RST_L;
			sync2_r <= PHASE_RST_L;
			prev_r <= PHASE_RST_L;
			step_r <= 1'b0;
			step_up_r <= 1'b1;
		end
		else if (ce)
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			step_r <= step_nxt;
			step_up_r <= step_up_nxt;
		end
	end

endmodule

`default_nettype wire

// *** testbench.sv ***
// self checking bench: device end and reader end joined by one interface
// assumes the shared package and interface are compiled first
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0; // 25 MHz clock
	logic rst = 1'b1; // reset
	logic ce = 1'b1; // clock enable, tied
	logic pa = 1'b0; // phase a pin
	logic pb = 1'b0; // phase b pin
	logic read_req = 1'b0; // read request
	logic wide_read = 1'b0; // two byte read
	logic read_busy; // reader busy
	logic read_done; // reader done
	logic [15:0] read_data; // value read
	logic [7:0] ext_latched; // cascade count at read
	logic [15:0] count_value; // live counter
	logic latch_frozen; // inhibit state
	logic [15:0] exp_cnt = 16'h0000; // expected count
	logic [1:0] seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00}; // up order of a,b
	logic frz; // inhibit seen during read
	int idx = 3; // phase position, 3 is a=0 b=0
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int dec_n = 0; // count pulses seen
	int cas_n = 0; // cascade pulses seen

	enc_read_if bif ();

	encoder_count_read_port u_encoder_count_read_port (.core_clk(core_clk), .rst(rst),
		.ce(ce), .encoder_phase_a(pa), .encoder_phase_b(pb), .bus(bif.dev),
		.count_value(count_value), .latch_frozen(latch_frozen));

	encoder_bus_reader u_encoder_bus_reader (.core_clk(core_clk), .rst(rst), .ce(ce),
		.bus(bif.host), .read_req(read_req), .wide_read(wide_read), .read_busy(read_busy),
		.read_done(read_done), .read_data(read_data), .ext_latched(ext_latched));

	enc_read_assertions u_enc_read_assertions (.core_clk(core_clk), .rst(rst),
		.byte_sel(bif.byte_sel), .bus_en_n(bif.bus_en_n), .data_out(bif.data_out),
		.data_oe(bif.data_oe), .decoder_count_pulse(bif.decoder_count_pulse),
		.carry_borrow_pulse(bif.carry_borrow_pulse), .up_down(bif.up_down));

	// clock
	always #20 core_clk = ~core_clk;

	// pulse tallies
	always @(posedge bif.decoder_count_pulse) dec_n++;
	always @(posedge bif.carry_borrow_pulse) cas_n++;

	// hang guard
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one quadrature state change, three cycles apart
	task automatic step(input logic up);
		idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
		exp_cnt = up ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001;
		{pa, pb} <= seq[idx];
		repeat (3) @(posedge core_clk);
	endtask

	task automatic settle();
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	// one read through the reader, noting the inhibit
	task automatic rd(input logic w);
		int n;
		n = 0;
		frz = 1'b0;
		read_req <= 1'b1;
		wide_read <= w;
		@(posedge core_clk);
		read_req <= 1'b0;
		#1;
		check(16'(read_busy), 16'h0001);
		while (read_done !== 1'b1 && n < 10)
		begin
			@(posedge core_clk);
			#1;
			frz |= latch_frozen;
			n++;
		end
		check(16'(n < 10), 16'h0001);
		check(16'(read_busy), 16'h0000);
		@(posedge core_clk);
	endtask

	task automatic t_count();
		repeat (5) step(1'b1);
		repeat (3) step(1'b0);
		settle();
		check(count_value, exp_cnt);
		check(16'(dec_n), 16'h0008);
		@(posedge core_clk);
	endtask

	// down through zero, then wide and single reads
	task automatic t_wrap_reads();
		repeat (4) step(1'b0);
		settle();
		check(count_value, 16'hfffe);
		check(16'(cas_n), 16'h0001);
		@(posedge core_clk);
		rd(1'b1);
		check(read_data, 16'hfffe);
		check(16'(frz), 16'h0001);
		check(16'(ext_latched), 16'h00ff);
		check(16'(latch_frozen), 16'h0000);
		rd(1'b0);
		check(read_data, 16'h00fe);
		check(16'(frz), 16'h0000);
	endtask

	// counter moves while the latch is held
	task automatic t_frozen();
		int d0;
		d0 = dec_n;
		step(1'b1);
		rd(1'b1);
		check(read_data, 16'hfffe);
		check(16'(dec_n - d0), 16'h0001);
		settle();
		check(count_value, 16'hffff);
		@(posedge core_clk);
		step(1'b1);
		settle();
		check(16'(cas_n), 16'h0002);
	endtask

	// reset in the middle of a read drops the inhibit at once
	task automatic t_reset_mid();
		while (idx != 3)
			step(1'b1);
		settle();
		@(posedge core_clk);
		read_req <= 1'b1;
		wide_read <= 1'b1;
		@(posedge core_clk);
		read_req <= 1'b0;
		@(posedge core_clk);
		#1;
		check(16'(latch_frozen), 16'h0001);
		@(posedge core_clk);
		rst <= 1'b1;
		#1;
		check(16'(latch_frozen), 16'h0000);
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		check(count_value, 16'h0000);
		check(read_data, 16'h0000);
	endtask

	// main sequence
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		settle();
		check(count_value, 16'h0000);
		@(posedge core_clk);
		t_count();
		t_wrap_reads();
		t_frozen();
		t_reset_mid();
		final_report();
	end
endmodule

`default_nettype wire
